// ---- adc_source_ref_clock_config.sv ----
// Converter configuration registers with input, reference and clock routing outputs.
// Assumes a byte-wide register port on the system clock, reads answering one cycle later.
//
// What this block does
// - Source code routes converter input as listed.
// - Internal source disconnects the external channel.
// - Reference code picks one of four references.
// - Internal reference disconnects external reference pin.
// - Divider code n from 1 to 7 gives system clock over 2^n; code 0 holds it low.
// - Sensor gain resets to 10, stored as written.
// - Amplifier input bit: pin or bandgap, exclusive.
// - Amplifier gain code picks four gains, resets 00.
// - Bandgap enable drives bandgap; off holds output low.
// - Hot calibration pair, left-justified, read only.
// - Warm calibration pair, same layout, read only.
// - Unimplemented bits read as zero.
// - External channel code 0 to 7, higher floats.
`timescale 1ns/1ps
module adc_source_ref_clock_config #(
  parameter logic [11:0] CAL_HOT = adc_cfg_pkg::CAL_HOT_DEFAULT, // Factory result at the hot point.
  parameter logic [11:0] CAL_WARM = adc_cfg_pkg::CAL_WARM_DEFAULT // Factory result at the warm point.
) (
  input wire logic ref_clk_i, // System clock, 40 MHz.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire adc_cfg_pkg::reg_req_t req_i, // Register address, data and strobes.
  output logic [7:0] rdata_o, // Read data, valid the cycle after a read strobe.
  output adc_cfg_pkg::input_route_t input_route_o, // Converter input switches.
  output adc_cfg_pkg::ref_route_t ref_route_o, // Converter reference switches.
  output logic conv_clk_o, // Converter clock.
  output logic conv_clk_valid_o, // Divider code is not reserved.
  output logic sensor_enable_o, // Temperature sensor power.
  output logic [1:0] sensor_gain_sel_o, // Temperature sensor gain code.
  output logic ref_amp_enable_o, // Reference amplifier power.
  output logic ref_amp_input_pin_o, // Amplifier input switch to the external pin.
  output logic ref_amp_bandgap_o, // Amplifier input switch to the bandgap.
  output logic [1:0] ref_amp_gain_sel_o, // Reference amplifier gain code.
  output logic bandgap_enable_o, // Bandgap on; low clamps its output low.
  output logic bandgap_clamp_o // Holds the bandgap output low while disabled.
);

  // ==========================================================================
  // Stored control fields.
  // ==========================================================================
  logic [2:0] input_source_sel;
  logic [1:0] reference_sel;
  logic [2:0] conv_clock_div_sel;
  logic [1:0] sensor_rsvd;
  logic [1:0] sensor_gain_sel;
  logic sensor_enable;
  logic ref_amp_enable;
  logic ref_amp_input_sel;
  logic [1:0] ref_amp_gain_sel;
  logic bandgap_enable;
  logic [3:0] ext_channel_sel;

  // ==========================================================================
  // Address decode.
  // ==========================================================================
  logic wr_sel;
  logic wr_sensor;
  logic wr_amp;
  logic wr_bandgap;
  logic wr_chan;

  assign wr_sel = req_i.wr && (req_i.addr == adc_cfg_pkg::OFS_INPUT_REF_CLOCK_SELECT);
  assign wr_sensor = req_i.wr && (req_i.addr == adc_cfg_pkg::OFS_TEMP_SENSOR_CONTROL);
  assign wr_amp = req_i.wr && (req_i.addr == adc_cfg_pkg::OFS_REF_AMPLIFIER_CONTROL);
  assign wr_bandgap = req_i.wr && (req_i.addr == adc_cfg_pkg::OFS_BANDGAP_CONTROL);
  assign wr_chan = req_i.wr && (req_i.addr == adc_cfg_pkg::OFS_EXT_CHANNEL_SELECT);
  // Calibration offsets have no write decode at all, so their values cannot change.

  // ==========================================================================
  // Read mux: assembled views of every register.
  // ==========================================================================
  logic [7:0] view_sel;
  logic [7:0] view_sensor;
  logic [7:0] view_amp;
  logic [7:0] view_bandgap;
  logic [7:0] view_chan;
  logic [7:0] next_rdata;

  assign view_sel = {input_source_sel, reference_sel, conv_clock_div_sel};
  assign view_sensor = {2'b00, sensor_rsvd, 1'b0, sensor_gain_sel, sensor_enable};
  assign view_amp = {ref_amp_enable, 2'b00, ref_amp_input_sel, 2'b00, ref_amp_gain_sel};
  assign view_bandgap = {7'h00, bandgap_enable};
  assign view_chan = {4'h0, ext_channel_sel};

  // Unmapped addresses read zero; the read data register holds zero between reads.
  always_comb begin
    next_rdata = 8'h00;
    if (req_i.rd) begin
      unique case (req_i.addr)
        adc_cfg_pkg::OFS_INPUT_REF_CLOCK_SELECT: next_rdata = view_sel;
        adc_cfg_pkg::OFS_TEMP_SENSOR_CONTROL: next_rdata = view_sensor;
        adc_cfg_pkg::OFS_REF_AMPLIFIER_CONTROL: next_rdata = view_amp;
        adc_cfg_pkg::OFS_BANDGAP_CONTROL: next_rdata = view_bandgap;
        adc_cfg_pkg::OFS_CAL_HOT_RESULT_HIGH: next_rdata = CAL_HOT[11:4];
        adc_cfg_pkg::OFS_CAL_HOT_RESULT_LOW: next_rdata = {CAL_HOT[3:0], 4'h0};
        adc_cfg_pkg::OFS_CAL_WARM_RESULT_HIGH: next_rdata = CAL_WARM[11:4];
        adc_cfg_pkg::OFS_CAL_WARM_RESULT_LOW: next_rdata = {CAL_WARM[3:0], 4'h0};
        adc_cfg_pkg::OFS_EXT_CHANNEL_SELECT: next_rdata = view_chan;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Register writes.
  // ==========================================================================
  // Source, reference and divider share one byte.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      input_source_sel <= adc_cfg_pkg::RST_INPUT_REF_CLOCK[7:5];
      reference_sel <= adc_cfg_pkg::RST_INPUT_REF_CLOCK[4:3];
      conv_clock_div_sel <= adc_cfg_pkg::RST_INPUT_REF_CLOCK[2:0];
    end else if (wr_sel) begin
      input_source_sel <= req_i.wdata[adc_cfg_pkg::INPUT_SRC_LSB +: 3];
      reference_sel <= req_i.wdata[adc_cfg_pkg::REF_SEL_LSB +: 2];
      conv_clock_div_sel <= req_i.wdata[adc_cfg_pkg::CLK_DIV_LSB +: 3];
    end
  end

  // The gain field is stored as written; the analog side accepts only the reset code, so software
  // is expected to leave it alone rather than hardware forcing it.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sensor_rsvd <= 2'b00;
      sensor_gain_sel <= adc_cfg_pkg::RST_SENSOR_GAIN;
      sensor_enable <= 1'b0;
    end else if (wr_sensor) begin
      sensor_rsvd <= req_i.wdata[adc_cfg_pkg::SENSOR_RSVD_LSB +: 2];
      sensor_gain_sel <= req_i.wdata[adc_cfg_pkg::SENSOR_GAIN_LSB +: 2];
      sensor_enable <= req_i.wdata[adc_cfg_pkg::SENSOR_EN_BIT];
    end
  end

  // Reference amplifier control.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_amp_enable <= 1'b0;
      ref_amp_input_sel <= 1'b0;
      ref_amp_gain_sel <= adc_cfg_pkg::RST_AMP_GAIN;
    end else if (wr_amp) begin
      ref_amp_enable <= req_i.wdata[adc_cfg_pkg::AMP_EN_BIT];
      ref_amp_input_sel <= req_i.wdata[adc_cfg_pkg::AMP_IN_BIT];
      ref_amp_gain_sel <= req_i.wdata[adc_cfg_pkg::AMP_GAIN_LSB +: 2];
    end
  end

  // Bandgap and external channel selection.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bandgap_enable <= 1'b0;
      ext_channel_sel <= adc_cfg_pkg::RST_EXT_CHANNEL;
    end else begin
      if (wr_bandgap) begin
        bandgap_enable <= req_i.wdata[adc_cfg_pkg::BANDGAP_EN_BIT];
      end
      if (wr_chan) begin
        ext_channel_sel <= req_i.wdata[3:0];
      end
    end
  end

  // ==========================================================================
  // Routing decode.
  // ==========================================================================
  adc_cfg_pkg::input_src_t src;
  adc_cfg_pkg::ref_src_t rsrc;
  logic ext_path;
  logic chan_in_range;
  logic [7:0] chan_onehot;
  adc_cfg_pkg::input_route_t next_input_route;
  adc_cfg_pkg::ref_route_t next_ref_route;

  assign src = adc_cfg_pkg::input_src_t'(input_source_sel);
  assign rsrc = adc_cfg_pkg::ref_src_t'(reference_sel);
  // Only the external code opens the pin path, so pin and internal signal never short together.
  assign ext_path = (src == adc_cfg_pkg::SRC_EXTERNAL);
  assign chan_in_range = (ext_channel_sel < adc_cfg_pkg::EXT_CHANNEL_COUNT);
  assign chan_onehot = (ext_path && chan_in_range) ? (8'h01 << ext_channel_sel[2:0]) : 8'h00;

  // Each code closes one switch, none for the external code with channel 8 or above; both ground codes share one switch.
  always_comb begin
    next_input_route = '0;
    next_input_route.ext_channel_on = chan_onehot;
    unique case (src)
      adc_cfg_pkg::SRC_EXTERNAL: next_input_route.ext_channel_on = chan_onehot;
      adc_cfg_pkg::SRC_AMP0: next_input_route.amp0_on = 1'b1;
      adc_cfg_pkg::SRC_AMP1: next_input_route.amp1_on = 1'b1;
      adc_cfg_pkg::SRC_GND_A, adc_cfg_pkg::SRC_GND_B: next_input_route.ground_on = 1'b1;
      adc_cfg_pkg::SRC_SUPPLY_QUARTER: next_input_route.supply_quarter_on = 1'b1;
      adc_cfg_pkg::SRC_SENSOR: next_input_route.sensor_out_on = 1'b1;
      adc_cfg_pkg::SRC_REF_AMP: next_input_route.ref_amp_out_on = 1'b1;
    endcase
  end

  // The external reference pin is closed only for code 00.
  always_comb begin
    next_ref_route = '0;
    unique case (rsrc)
      adc_cfg_pkg::REF_EXT_PIN: next_ref_route.ext_pin_on = 1'b1;
      adc_cfg_pkg::REF_SUPPLY: next_ref_route.supply_on = 1'b1;
      adc_cfg_pkg::REF_AMP_OUT: next_ref_route.amp_out_on = 1'b1;
      adc_cfg_pkg::REF_SENSOR: next_ref_route.sensor_ref_on = 1'b1;
    endcase
  end

  // ==========================================================================
  // Output registers: routing lags the register write by one cycle.
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
      input_route_o <= '0;
      ref_route_o <= '0;
      sensor_enable_o <= 1'b0;
      sensor_gain_sel_o <= adc_cfg_pkg::RST_SENSOR_GAIN;
      ref_amp_enable_o <= 1'b0;
      ref_amp_input_pin_o <= 1'b0;
      ref_amp_bandgap_o <= 1'b0;
      ref_amp_gain_sel_o <= adc_cfg_pkg::RST_AMP_GAIN;
      bandgap_enable_o <= 1'b0;
      bandgap_clamp_o <= 1'b1;
    end else begin
      rdata_o <= next_rdata;
      input_route_o <= next_input_route;
      ref_route_o <= next_ref_route;
      sensor_enable_o <= sensor_enable;
      sensor_gain_sel_o <= sensor_gain_sel;
      ref_amp_enable_o <= ref_amp_enable;
      ref_amp_input_pin_o <= !ref_amp_input_sel;
      ref_amp_bandgap_o <= ref_amp_input_sel;
      ref_amp_gain_sel_o <= ref_amp_gain_sel;
      bandgap_enable_o <= bandgap_enable;
      bandgap_clamp_o <= !bandgap_enable;
    end
  end

  // ==========================================================================
  // Converter clock.
  // ==========================================================================
  conv_clock_divider clock_div (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .div_sel_i(conv_clock_div_sel),
    .conv_clk_o(conv_clk_o),
    .div_valid_o(conv_clk_valid_o)
  );

endmodule

// ---- adc_cfg_pkg.sv ----
// Package for the converter configuration block: register offsets, field layout, reset values and types.
// Assumes a byte-wide register port with one-cycle read latency and a 40 MHz system clock.
package adc_cfg_pkg;

  // ==========================================================================
  // Register offsets (byte index on the register port).
  // ==========================================================================
  localparam logic [3:0] OFS_INPUT_REF_CLOCK_SELECT = 4'h0;
  localparam logic [3:0] OFS_TEMP_SENSOR_CONTROL = 4'h1;
  localparam logic [3:0] OFS_REF_AMPLIFIER_CONTROL = 4'h2;
  localparam logic [3:0] OFS_BANDGAP_CONTROL = 4'h3;
  localparam logic [3:0] OFS_CAL_HOT_RESULT_HIGH = 4'h4;
  localparam logic [3:0] OFS_CAL_HOT_RESULT_LOW = 4'h5;
  localparam logic [3:0] OFS_CAL_WARM_RESULT_HIGH = 4'h6;
  localparam logic [3:0] OFS_CAL_WARM_RESULT_LOW = 4'h7;
  localparam logic [3:0] OFS_EXT_CHANNEL_SELECT = 4'h8;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int INPUT_SRC_LSB = 5;
  localparam int REF_SEL_LSB = 3;
  localparam int CLK_DIV_LSB = 0;
  localparam int SENSOR_RSVD_LSB = 4;
  localparam int SENSOR_GAIN_LSB = 1;
  localparam int SENSOR_EN_BIT = 0;
  localparam int AMP_EN_BIT = 7;
  localparam int AMP_IN_BIT = 4;
  localparam int AMP_GAIN_LSB = 0;
  localparam int BANDGAP_EN_BIT = 0;
  localparam int CAL_LOW_LSB = 4;

  // ==========================================================================
  // Reset values and fixed codes.
  // ==========================================================================
  localparam logic [7:0] RST_INPUT_REF_CLOCK = 8'h00;
  localparam logic [1:0] RST_SENSOR_GAIN = 2'h2;
  localparam logic [1:0] RST_AMP_GAIN = 2'h0;
  localparam logic [3:0] RST_EXT_CHANNEL = 4'h0;
  localparam logic [11:0] CAL_HOT_DEFAULT = 12'h000;
  localparam logic [11:0] CAL_WARM_DEFAULT = 12'h000;
  localparam logic [3:0] EXT_CHANNEL_COUNT = 4'h8;
  localparam logic [7:0] DIVIDER_RESERVED_CODE = 8'h00;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [2:0] {
    SRC_EXTERNAL = 3'b000,
    SRC_AMP0 = 3'b001,
    SRC_AMP1 = 3'b010,
    SRC_GND_A = 3'b011,
    SRC_GND_B = 3'b100,
    SRC_SUPPLY_QUARTER = 3'b101,
    SRC_SENSOR = 3'b110,
    SRC_REF_AMP = 3'b111
  } input_src_t;

  typedef enum logic [1:0] {
    REF_EXT_PIN = 2'b00,
    REF_SUPPLY = 2'b01,
    REF_AMP_OUT = 2'b10,
    REF_SENSOR = 2'b11
  } ref_src_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // At most one-hot routing switches toward the analog front end.
  typedef struct packed {
    logic [7:0] ext_channel_on;
    logic amp0_on;
    logic amp1_on;
    logic ground_on;
    logic supply_quarter_on;
    logic sensor_out_on;
    logic ref_amp_out_on;
  } input_route_t;

  typedef struct packed {
    logic ext_pin_on;
    logic supply_on;
    logic amp_out_on;
    logic sensor_ref_on;
  } ref_route_t;

endpackage

// ---- conv_clock_divider.sv ----
// Converter clock divider: a free-running counter whose tapped bit forms the converter clock.
// Assumes the selection code comes from a register in the same clock domain.
`timescale 1ns/1ps
module conv_clock_divider (
  input wire logic ref_clk_i, // System clock.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic [2:0] div_sel_i, // Divider code, 1 gives /2 up to 7 giving /128.
  output logic conv_clk_o, // Converter clock, registered.
  output logic div_valid_o // High when the code is not the reserved one.
);

  // ==========================================================================
  // Counter and tap selection.
  // ==========================================================================
  logic [6:0] count;
  logic [6:0] next_count;
  logic tap;
  logic code_ok;

  // Bit n-1 of the counter toggles at sys/2^n, so code n taps bit n-1.
  assign next_count = count + 7'h01;
  assign code_ok = (div_sel_i != 3'h0);
  assign tap = code_ok ? count[div_sel_i - 3'h1] : 1'b0;

  // Output is registered so the converter clock carries no decode glitches.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 7'h00;
      conv_clk_o <= 1'b0;
      div_valid_o <= 1'b0;
    end else begin
      count <= next_count;
      conv_clk_o <= tap;
      div_valid_o <= code_ok;
    end
  end

endmodule

// ---- adc_source_ref_clock_config_sva.sv ----
// Checker for the converter configuration block: routing, reset and read-data relations.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module adc_source_ref_clock_config_sva #(
  parameter logic [11:0] CAL_HOT = 12'h000, // Hot calibration value.
  parameter logic [11:0] CAL_WARM = 12'h000 // Warm calibration value.
) (
  input wire logic ref_clk_i, // System clock.
  input wire logic arst_n_i, // Reset, active low.
  input wire adc_cfg_pkg::reg_req_t req_i, // Register request.
  input wire logic [7:0] rdata_o, // Read data.
  input wire adc_cfg_pkg::input_route_t input_route_o, // Input switches.
  input wire adc_cfg_pkg::ref_route_t ref_route_o, // Reference switches.
  input wire logic conv_clk_o, // Converter clock.
  input wire logic conv_clk_valid_o, // Divider code valid.
  input wire logic [1:0] sensor_gain_sel_o, // Sensor gain.
  input wire logic ref_amp_input_pin_o, // Amplifier pin switch.
  input wire logic ref_amp_bandgap_o, // Amplifier bandgap switch.
  input wire logic [1:0] ref_amp_gain_sel_o, // Amplifier gain.
  input wire logic bandgap_enable_o, // Bandgap on.
  input wire logic bandgap_clamp_o // Bandgap clamp.
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  // One clock domain; outputs lag a write by two edges, so a second write is excluded.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_IN_ONEHOT: assert property ($onehot0(input_route_o))
    else $error("input switches not one-hot");
  AST_EXT_OFF: assert property (req_i.wr && req_i.addr == 4'h0 && req_i.wdata[7:5] != 3'b000
    ##1 !(req_i.wr && req_i.addr == 4'h0) |-> ##1 input_route_o.ext_channel_on == 8'h00)
    else $error("external channel joined to internal source");
  AST_REF_ONEHOT: assert property ($past(arst_n_i) |-> $onehot(ref_route_o))
    else $error("reference switches not one-hot");
  AST_REF_PIN_OFF: assert property (req_i.wr && req_i.addr == 4'h0 && req_i.wdata[4:3] != 2'b00
    ##1 !(req_i.wr && req_i.addr == 4'h0) |-> ##1 !ref_route_o.ext_pin_on)
    else $error("reference pin left on");
  AST_DIV_RSVD: assert property (req_i.wr && req_i.addr == 4'h0 && req_i.wdata[2:0] == 3'b000
    ##1 !(req_i.wr && req_i.addr == 4'h0) |-> ##1 !conv_clk_valid_o)
    else $error("reserved divider code flagged valid");
  AST_CLK_STILL: assert property (!conv_clk_valid_o && !$past(conv_clk_valid_o)
    && !$past(conv_clk_valid_o, 2) |-> !conv_clk_o)
    else $error("converter clock toggles on reserved code");
  AST_GAIN_RST: assert property ($rose(arst_n_i) |-> sensor_gain_sel_o == 2'b10
    && ref_amp_gain_sel_o == 2'b00)
    else $error("gain reset value wrong");
  AST_AMP_IN: assert property ($past(arst_n_i) |-> ref_amp_input_pin_o != ref_amp_bandgap_o)
    else $error("amplifier input switches not exclusive");
  AST_BG_CLAMP: assert property (bandgap_clamp_o == !bandgap_enable_o)
    else $error("bandgap clamp disagrees with enable");
  AST_CAL_HOT: assert property ($past(req_i.rd) && ($past(req_i.addr) == 4'h4 || $past(req_i.addr) == 4'h5)
    |-> rdata_o == ($past(req_i.addr) == 4'h5 ? {CAL_HOT[3:0], 4'h0} : CAL_HOT[11:4]))
    else $error("hot calibration read wrong");
  AST_CAL_WARM: assert property ($past(req_i.rd) && ($past(req_i.addr) == 4'h6 || $past(req_i.addr) == 4'h7)
    |-> rdata_o == ($past(req_i.addr) == 4'h7 ? {CAL_WARM[3:0], 4'h0} : CAL_WARM[11:4]))
    else $error("warm calibration read wrong");
  AST_UNIMP_ZERO: assert property ($past(req_i.rd) && ($past(req_i.addr) == 4'h2 || $past(req_i.addr) == 4'h3)
    |-> (rdata_o & ($past(req_i.addr) == 4'h3 ? 8'hFE : 8'h6C)) == 8'h00)
    else $error("unimplemented bits read nonzero");
endmodule

bind adc_source_ref_clock_config adc_source_ref_clock_config_sva #(.CAL_HOT(CAL_HOT), .CAL_WARM(CAL_WARM))
  sva_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .rdata_o(rdata_o),
  .input_route_o(input_route_o), .ref_route_o(ref_route_o), .conv_clk_o(conv_clk_o),
  .conv_clk_valid_o(conv_clk_valid_o), .sensor_gain_sel_o(sensor_gain_sel_o),
  .ref_amp_input_pin_o(ref_amp_input_pin_o), .ref_amp_bandgap_o(ref_amp_bandgap_o),
  .ref_amp_gain_sel_o(ref_amp_gain_sel_o), .bandgap_enable_o(bandgap_enable_o),
  .bandgap_clamp_o(bandgap_clamp_o));

// ---- adc_source_ref_clock_config_bench.sv ----
// Self-checking bench for the converter configuration block.
// Assumes the package and checker are compiled first; 40 MHz clock.
`timescale 1ns/1ps
module adc_source_ref_clock_config_bench;
  localparam logic [11:0] HOT = 12'hA5C; // Arbitrary test value.
  localparam logic [11:0] WARM = 12'h3B7; // Arbitrary test value.
  logic ref_clk_i, arst_n_i, conv_clk_o, conv_clk_valid_o, sensor_enable_o, ref_amp_enable_o;
  logic ref_amp_input_pin_o, ref_amp_bandgap_o, bandgap_enable_o, bandgap_clamp_o;
  logic [1:0] sensor_gain_sel_o, ref_amp_gain_sel_o;
  logic [7:0] rdata_o;
  adc_cfg_pkg::reg_req_t req_i;
  adc_cfg_pkg::input_route_t input_route_o;
  adc_cfg_pkg::ref_route_t ref_route_o;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  adc_source_ref_clock_config #(.CAL_HOT(HOT), .CAL_WARM(WARM)) adc_source_ref_clock_config_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .input_route_o(input_route_o), .ref_route_o(ref_route_o), .conv_clk_o(conv_clk_o),
    .conv_clk_valid_o(conv_clk_valid_o), .sensor_enable_o(sensor_enable_o),
    .sensor_gain_sel_o(sensor_gain_sel_o), .ref_amp_enable_o(ref_amp_enable_o),
    .ref_amp_input_pin_o(ref_amp_input_pin_o), .ref_amp_bandgap_o(ref_amp_bandgap_o),
    .ref_amp_gain_sel_o(ref_amp_gain_sel_o), .bandgap_enable_o(bandgap_enable_o),
    .bandgap_clamp_o(bandgap_clamp_o));

  // ==========================================================================
  // Clock, timeout and helpers
  // ==========================================================================
  // Free-running clock, 25 ns period.
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // The longest test needs well under 10000 cycles, so a stall is cut off here.
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_i.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req_i.rd <= 1'b0;
    #1;
    chk_rd(rdata_o, exp);
  endtask

  // Routing outputs follow the register one edge later.
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h04);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h4, HOT[11:4]);
    rd(4'h5, {HOT[3:0], 4'h0});
    rd(4'h6, WARM[11:4]);
    rd(4'h7, {WARM[3:0], 4'h0});
    chk_out(16'({sensor_gain_sel_o, bandgap_clamp_o}), 16'h0005);
  endtask

  task automatic t_sources();
    logic [13:0] exp;
    wr(4'h8, 8'h03);
    for (int s = 0; s < 8; s++) begin
      wr(4'h0, {3'(s), 5'h01});
      settle();
      exp = (s == 0) ? 14'h0200 : (s < 4) ? 14'h0001 << (6 - s) : (s == 4) ? 14'h0008 : 14'h0001 << (7 - s);
      chk_out(16'(input_route_o), 16'(exp));
    end
    wr(4'h0, 8'h01);
    wr(4'h8, 8'h07);
    settle();
    chk_out(16'(input_route_o), 16'h2000);
    wr(4'h8, 8'h09);
    settle();
    chk_out(16'(input_route_o), 16'h0000);
  endtask

  task automatic t_refs();
    for (int r = 0; r < 4; r++) begin
      wr(4'h0, {3'h0, 2'(r), 3'h1});
      settle();
      chk_out(16'(ref_route_o), 16'(4'h8 >> r));
    end
  endtask

  // Periods are timed between the second and third rising edge, after any restart glitch.
  task automatic t_divider();
    int n;
    int per;
    int rises;
    logic prev;
    wr(4'h0, 8'h00);
    settle();
    n = 0;
    repeat (300) begin
      @(posedge ref_clk_i);
      #1;
      n += int'(conv_clk_o === 1'b1);
    end
    chk_out(16'({conv_clk_valid_o, 15'(n)}), 16'h0000);
    for (int c = 1; c < 8; c++) begin
      wr(4'h0, 8'(c));
      rises = 0;
      per = 0;
      prev = conv_clk_o;
      for (n = 0; n < 600 && rises < 3; n++) begin
        @(posedge ref_clk_i);
        #1;
        per++;
        if (conv_clk_o === 1'b1 && prev === 1'b0) begin
          rises++;
          if (rises == 2) begin
            per = 0;
          end
        end
        prev = conv_clk_o;
      end
      chk_out(16'({conv_clk_valid_o, 15'(per)}), 16'h8000 | 16'(1 << c));
    end
  endtask

  task automatic t_regs();
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h37);
    wr(4'h1, 8'h05);
    settle();
    chk_out(16'({sensor_enable_o, sensor_gain_sel_o}), 16'h0006);
    wr(4'h3, 8'hFF);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h93);
    rd(4'h3, 8'h01);
    chk_out(16'({ref_amp_enable_o, ref_amp_input_pin_o, ref_amp_bandgap_o, ref_amp_gain_sel_o,
      bandgap_enable_o, bandgap_clamp_o}), 16'h005E);
    wr(4'h3, 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(4'h2, {6'h00, 2'(g)});
      settle();
      chk_out(16'({ref_amp_input_pin_o, ref_amp_bandgap_o, ref_amp_gain_sel_o,
        bandgap_enable_o, bandgap_clamp_o}), 16'h0021 | 16'(g << 2));
    end
    wr(4'h4, 8'h00);
    wr(4'h7, 8'hFF);
    rd(4'h4, HOT[11:4]);
    rd(4'h7, {WARM[3:0], 4'h0});
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    rd(4'hF, 8'h00);
  endtask

  // Main sequence, with a second reset in mid-run.
  initial begin
    arst_n_i = 1'b0;
    req_i = '0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_sources();
    t_refs();
    t_divider();
    t_regs();
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    results();
  end
endmodule
